// ---- src/ulfs_defines.svh ----
// Register indices, field positions, reset values and bit timing of the serial line block.
// Included by the top module; definitions only.
`ifndef ULFS_DEFINES_SVH
`define ULFS_DEFINES_SVH
// Register indices; byte address is four times the index
`define ULFS_IDX_DATA 3'h0
`define ULFS_IDX_IER 3'h1
`define ULFS_IDX_IIR 3'h2
`define ULFS_IDX_LCR 3'h3
`define ULFS_IDX_LSR 3'h5
`define ULFS_IDX_MSR 3'h6
// Source identification codes
`define ULFS_IIR_NONE 8'h01
`define ULFS_IIR_LSI 8'h06
`define ULFS_IIR_RDA 8'h04
`define ULFS_IIR_TX_HOLDING_EMPTY 8'h02
`define ULFS_IIR_MS 8'h00
// Line format control fields
`define ULFS_LCR_STB 2
`define ULFS_LCR_PEN 3
`define ULFS_LCR_EPS 4
`define ULFS_LCR_STICK 5
`define ULFS_LCR_BRK 6
`define ULFS_LCR_DIVISOR_ACCESS_SELECT 7
// Interrupt enable fields
`define ULFS_IER_RDA 0
`define ULFS_IER_TX_HOLDING_EMPTY 1
`define ULFS_IER_LSI 2
`define ULFS_IER_MS 3
// Last 16x tick of a bit, mid-bit sample point, long stop periods
`define ULFS_TICK_LAST 5'h0F
`define ULFS_TICK_MID 5'h07
`define ULFS_STOP15_LAST 5'h17
`define ULFS_STOP2_LAST 5'h1F
// Reset values
// Low divisor byte; the high byte resets to zero, giving a divisor of one
`define ULFS_DIV_RST 8'h01
`define ULFS_LCR_RST 8'h00
`define ULFS_PIN_RST 5'h1F
`endif

// ---- src/ulfs_pkg.sv ----
// Types of the serial line block: sequencer states, bus request and the state record.
// Assumes the defines header is on the include path.
package ulfs_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulfs_tx_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ulfs_rx_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] idx;
    logic [7:0] wdata;
  } ulfs_req_t;
  typedef struct packed {
    logic waitreq;
    logic [7:0] rdata;
    logic intr;
    logic serial_tx_out;
    logic [7:0] line_format_control;
    logic [3:0] interrupt_enable_reg;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic [15:0] baud_cnt;
    logic tick;
    logic [7:0] transmit_holding;
    logic thr_full;
    logic tx_holding_empty_int;
    logic [7:0] tsr;
    ulfs_tx_t tx_st;
    logic [4:0] tx_tcnt;
    logic [2:0] tx_bits;
    logic tx_par;
    ulfs_rx_t rx_st;
    logic [4:0] rx_tcnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_sh;
    logic rx_par;
    logic rx_prev;
    logic [7:0] receive_buffer;
    logic dr;
    logic oe;
    logic pe;
    logic fe;
    logic bi;
    logic [3:0] msr_d;
    logic [3:0] msr_s;
    logic [4:0] sync1;
    logic [4:0] sync2;
  } ulfs_state_t;
endpackage

// ---- src/ulfs_top.sv ----
// Serial line element: format control, line status, prioritised interrupt identification,
// transmitter, receiver, baud divider and modem-line change detection.
// Assumes an Avalon-MM master with waitrequest, one 100 MHz clock, async pins on serial/modem.
`timescale 1ns/1ps
`include "ulfs_defines.svh"

module ulfs_top import ulfs_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Serial line
  input wire logic i_serial_rx_in,
  output logic o_serial_tx_out,
  // Modem inputs, active low
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_ri_n,
  input wire logic i_dcd_n,
  // Interrupt request
  output logic o_intr
);

  ulfs_state_t state_ff;
  ulfs_state_t nxt_state;
  ulfs_req_t req;
  logic acc_rd;
  logic acc_wr;
  logic divisor_access_select;
  logic pend_ls;
  logic pend_rda;
  logic pend_tx_holding_empty;
  logic pend_ms;
  logic [7:0] iir_now;
  logic [7:0] lsr_now;
  logic [7:0] rd_mux;
  logic [2:0] wlast;
  logic [4:0] stop_last;
  logic rx_bit;
  logic tx_bit;
  logic [7:0] rx_data;
  logic rx_done;

  function automatic logic [7:0] len_mask(input logic [1:0] wls);
    len_mask = 8'hFF >> (2'h3 - wls);
  endfunction

  // Parity bit for a masked character under the current format
  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_format_control);
    if (line_format_control[`ULFS_LCR_STICK]) begin
      par_bit = ~line_format_control[`ULFS_LCR_EPS];
    end else begin
      par_bit = line_format_control[`ULFS_LCR_EPS] ? ^d : ~^d;
    end
  endfunction

  assign req.rd = i_avs_read;
  assign req.wr = i_avs_write;
  assign req.idx = i_avs_address[4:2];
  assign req.wdata = i_avs_writedata[7:0];
  // A request is served at the edge where waitrequest is seen low
  assign acc_rd = req.rd && !state_ff.waitreq;
  assign acc_wr = req.wr && !state_ff.waitreq;
  assign divisor_access_select = state_ff.line_format_control[`ULFS_LCR_DIVISOR_ACCESS_SELECT];

  assign pend_ls = state_ff.interrupt_enable_reg[`ULFS_IER_LSI] &&
    (state_ff.oe || state_ff.pe || state_ff.fe || state_ff.bi);
  assign pend_rda = state_ff.interrupt_enable_reg[`ULFS_IER_RDA] && state_ff.dr;
  assign pend_tx_holding_empty = state_ff.interrupt_enable_reg[`ULFS_IER_TX_HOLDING_EMPTY] && state_ff.tx_holding_empty_int;
  assign pend_ms = state_ff.interrupt_enable_reg[`ULFS_IER_MS] && (|state_ff.msr_d);

  always_comb begin
    if (pend_ls) begin
      iir_now = `ULFS_IIR_LSI;
    end else if (pend_rda) begin
      iir_now = `ULFS_IIR_RDA;
    end else if (pend_tx_holding_empty) begin
      iir_now = `ULFS_IIR_TX_HOLDING_EMPTY;
    end else if (pend_ms) begin
      iir_now = `ULFS_IIR_MS;
    end else begin
      iir_now = `ULFS_IIR_NONE;
    end
  end

  // Transmitter empty needs both stages empty; bit 7 is tied low
  assign lsr_now = {1'b0, !state_ff.thr_full && state_ff.tx_st == TX_IDLE,
    !state_ff.thr_full, state_ff.bi, state_ff.fe, state_ff.pe, state_ff.oe, state_ff.dr};

  always_comb begin
    if (req.idx == `ULFS_IDX_DATA) begin
      rd_mux = divisor_access_select ? state_ff.dll : state_ff.receive_buffer;
    end else if (req.idx == `ULFS_IDX_IER) begin
      rd_mux = divisor_access_select ? state_ff.dlm : {4'h0, state_ff.interrupt_enable_reg};
    end else if (req.idx == `ULFS_IDX_IIR) begin
      rd_mux = iir_now;
    end else if (req.idx == `ULFS_IDX_LCR) begin
      rd_mux = state_ff.line_format_control;
    end else if (req.idx == `ULFS_IDX_LSR) begin
      rd_mux = lsr_now;
    end else if (req.idx == `ULFS_IDX_MSR) begin
      rd_mux = {state_ff.msr_s, state_ff.msr_d};
    end else begin
      rd_mux = 8'h00;
    end
  end

  assign wlast = {1'b0, state_ff.line_format_control[1:0]} + 3'h4;
  assign stop_last = !state_ff.line_format_control[`ULFS_LCR_STB] ? `ULFS_TICK_LAST :
    (state_ff.line_format_control[1:0] == 2'h0) ? `ULFS_STOP15_LAST : `ULFS_STOP2_LAST;
  assign rx_bit = state_ff.sync2[0];
  assign rx_data = state_ff.rx_sh >> (2'h3 - state_ff.line_format_control[1:0]);
  assign rx_done = state_ff.tick && state_ff.rx_st == RX_STOP &&
    state_ff.rx_tcnt == `ULFS_TICK_LAST;

  always_comb begin
    case (state_ff.tx_st)
      TX_START: tx_bit = 1'b0;
      TX_DATA: tx_bit = state_ff.tsr[0];
      TX_PAR: tx_bit = state_ff.tx_par;
      default: tx_bit = 1'b1;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    // Baud divider: one 16x tick per divisor count
    nxt_state.tick = 1'b0;
    if (state_ff.baud_cnt <= 16'h0001) begin
      nxt_state.baud_cnt = {state_ff.dlm, state_ff.dll};
      nxt_state.tick = 1'b1;
    end else begin
      nxt_state.baud_cnt = state_ff.baud_cnt - 16'h0001;
    end
    nxt_state.sync1 = {i_dcd_n, i_ri_n, i_dsr_n, i_cts_n, i_serial_rx_in};
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.rx_prev = rx_bit;

    // Bus: capture read data one edge early, then release waitrequest
    nxt_state.waitreq = !((req.rd || req.wr) && state_ff.waitreq);
    if ((req.rd || req.wr) && state_ff.waitreq) begin
      nxt_state.rdata = rd_mux;
    end
    // Read side effects first so hardware events this cycle win over them
    if (acc_rd) begin
      if (req.idx == `ULFS_IDX_DATA && !divisor_access_select) begin
        nxt_state.dr = 1'b0;
      end else if (req.idx == `ULFS_IDX_LSR) begin
        nxt_state.oe = 1'b0;
        nxt_state.pe = 1'b0;
        nxt_state.fe = 1'b0;
        nxt_state.bi = 1'b0;
      end else if (req.idx == `ULFS_IDX_IIR && state_ff.rdata == `ULFS_IIR_TX_HOLDING_EMPTY) begin
        nxt_state.tx_holding_empty_int = 1'b0;
      end else if (req.idx == `ULFS_IDX_MSR) begin
        nxt_state.msr_d = 4'h0;
      end
    end

    // Transmitter: holding register moves to the shifter when idle
    if (state_ff.tx_st == TX_IDLE && state_ff.thr_full) begin
      nxt_state.tsr = state_ff.transmit_holding & len_mask(state_ff.line_format_control[1:0]);
      nxt_state.tx_par = par_bit(state_ff.transmit_holding & len_mask(state_ff.line_format_control[1:0]), state_ff.line_format_control);
      nxt_state.thr_full = 1'b0;
      nxt_state.tx_holding_empty_int = 1'b1;
      nxt_state.tx_st = TX_START;
      nxt_state.tx_tcnt = 5'h00;
    end else if (state_ff.tick && state_ff.tx_st != TX_IDLE) begin
      nxt_state.tx_tcnt = state_ff.tx_tcnt + 5'h01;
      case (state_ff.tx_st)
        TX_START: begin
          if (state_ff.tx_tcnt == `ULFS_TICK_LAST) begin
            nxt_state.tx_st = TX_DATA;
            nxt_state.tx_tcnt = 5'h00;
            nxt_state.tx_bits = 3'h0;
          end
        end
        TX_DATA: begin
          if (state_ff.tx_tcnt == `ULFS_TICK_LAST) begin
            nxt_state.tx_tcnt = 5'h00;
            nxt_state.tsr = state_ff.tsr >> 1;
            nxt_state.tx_bits = state_ff.tx_bits + 3'h1;
            if (state_ff.tx_bits == wlast) begin
              nxt_state.tx_st = state_ff.line_format_control[`ULFS_LCR_PEN] ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          if (state_ff.tx_tcnt == `ULFS_TICK_LAST) begin
            nxt_state.tx_st = TX_STOP;
            nxt_state.tx_tcnt = 5'h00;
          end
        end
        TX_STOP: begin
          if (state_ff.tx_tcnt == stop_last) begin
            nxt_state.tx_st = TX_IDLE;
          end
        end
        default: nxt_state.tx_st = TX_IDLE;
      endcase
    end
    // Break only forces the pin; the sequencer keeps running
    nxt_state.serial_tx_out = state_ff.line_format_control[`ULFS_LCR_BRK] ? 1'b0 : tx_bit;

    // Bus writes; a holding write clears the empty flag
    if (acc_wr) begin
      if (req.idx == `ULFS_IDX_DATA && divisor_access_select) begin
        nxt_state.dll = req.wdata;
        nxt_state.baud_cnt = {state_ff.dlm, req.wdata};
      end else if (req.idx == `ULFS_IDX_DATA) begin
        nxt_state.transmit_holding = req.wdata;
        nxt_state.thr_full = 1'b1;
        nxt_state.tx_holding_empty_int = 1'b0;
      end else if (req.idx == `ULFS_IDX_IER && divisor_access_select) begin
        nxt_state.dlm = req.wdata;
        nxt_state.baud_cnt = {req.wdata, state_ff.dll};
      end else if (req.idx == `ULFS_IDX_IER) begin
        nxt_state.interrupt_enable_reg = req.wdata[3:0];
      end else if (req.idx == `ULFS_IDX_LCR) begin
        nxt_state.line_format_control = req.wdata;
      end
    end

    // Receiver: 16x oversampling, start verified at mid-bit
    if (state_ff.tick) begin
      nxt_state.rx_tcnt = state_ff.rx_tcnt + 5'h01;
      case (state_ff.rx_st)
        RX_IDLE: begin
          if (state_ff.rx_prev && !rx_bit) begin
            nxt_state.rx_st = RX_START;
            nxt_state.rx_tcnt = 5'h00;
          end
        end
        RX_START: begin
          if (state_ff.rx_tcnt == `ULFS_TICK_MID) begin
            nxt_state.rx_st = rx_bit ? RX_IDLE : RX_DATA;
            nxt_state.rx_tcnt = 5'h00;
            nxt_state.rx_bits = 3'h0;
          end
        end
        RX_DATA: begin
          if (state_ff.rx_tcnt == `ULFS_TICK_LAST) begin
            nxt_state.rx_tcnt = 5'h00;
            nxt_state.rx_sh = {rx_bit, state_ff.rx_sh[7:1]};
            nxt_state.rx_bits = state_ff.rx_bits + 3'h1;
            if (state_ff.rx_bits == wlast) begin
              nxt_state.rx_st = state_ff.line_format_control[`ULFS_LCR_PEN] ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (state_ff.rx_tcnt == `ULFS_TICK_LAST) begin
            nxt_state.rx_tcnt = 5'h00;
            nxt_state.rx_par = rx_bit;
            nxt_state.rx_st = RX_STOP;
          end
        end
        RX_STOP: begin
          // Only the first stop bit is looked at
          if (state_ff.rx_tcnt == `ULFS_TICK_LAST) begin
            nxt_state.rx_st = RX_IDLE;
            nxt_state.receive_buffer = rx_data;
            nxt_state.dr = 1'b1;
            if (state_ff.dr) begin
              nxt_state.oe = 1'b1;
            end
            if (state_ff.line_format_control[`ULFS_LCR_PEN] &&
                state_ff.rx_par != par_bit(rx_data, state_ff.line_format_control)) begin
              nxt_state.pe = 1'b1;
            end
            if (!rx_bit) begin
              nxt_state.fe = 1'b1;
            end
            // Low through start, data, parity and stop means a break
            if (!rx_bit && rx_data == 8'h00 &&
                !(state_ff.line_format_control[`ULFS_LCR_PEN] && state_ff.rx_par)) begin
              nxt_state.bi = 1'b1;
            end
          end
        end
        default: nxt_state.rx_st = RX_IDLE;
      endcase
    end

    // Modem line changes, ring only on its trailing edge; a change wins over a same-cycle clear
    nxt_state.msr_s = ~state_ff.sync2[4:1];
    nxt_state.msr_d[0] = nxt_state.msr_d[0] | (state_ff.msr_s[0] ^ ~state_ff.sync2[1]);
    nxt_state.msr_d[1] = nxt_state.msr_d[1] | (state_ff.msr_s[1] ^ ~state_ff.sync2[2]);
    nxt_state.msr_d[2] = nxt_state.msr_d[2] | (state_ff.msr_s[2] & state_ff.sync2[3]);
    nxt_state.msr_d[3] = nxt_state.msr_d[3] | (state_ff.msr_s[3] ^ ~state_ff.sync2[4]);

    nxt_state.intr = pend_ls || pend_rda || pend_tx_holding_empty || pend_ms;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
      state_ff.waitreq <= 1'b1;
      state_ff.serial_tx_out <= 1'b1;
      state_ff.line_format_control <= `ULFS_LCR_RST;
      state_ff.dll <= `ULFS_DIV_RST;
      state_ff.tx_st <= TX_IDLE;
      state_ff.rx_st <= RX_IDLE;
      state_ff.rx_prev <= 1'b1;
      state_ff.sync1 <= `ULFS_PIN_RST;
      state_ff.sync2 <= `ULFS_PIN_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_avs_readdata = {24'h000000, state_ff.rdata};
  assign o_avs_waitrequest = state_ff.waitreq;
  assign o_serial_tx_out = state_ff.serial_tx_out;
  assign o_intr = state_ff.intr;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_lsr_rd;
    acc_rd && req.idx == `ULFS_IDX_LSR && !rx_done;
  endsequence
  sequence s_rbr_rd;
    acc_rd && req.idx == `ULFS_IDX_DATA && !divisor_access_select && !rx_done;
  endsequence
  sequence s_thr_wr;
    acc_wr && req.idx == `ULFS_IDX_DATA && !divisor_access_select;
  endsequence

  chk_iir_top: assert property (pend_ls |-> iir_now == `ULFS_IIR_LSI)
    else $error("line status not reported first");
  chk_iir_second: assert property (!pend_ls && pend_rda |-> iir_now == `ULFS_IIR_RDA)
    else $error("data available code wrong");
  chk_iir_idle: assert property (iir_now[0] == !(pend_ls || pend_rda || pend_tx_holding_empty || pend_ms))
    else $error("pending bit disagrees with sources");
  chk_irq_gate: assert property (o_intr == $past(iir_now[0] == 1'b0))
    else $error("interrupt output not tied to enabled sources");
  chk_break_out: assert property (state_ff.line_format_control[`ULFS_LCR_BRK] |=> !o_serial_tx_out)
    else $error("break did not hold line low");
  chk_ready_clear: assert property (s_rbr_rd |=> !state_ff.dr)
    else $error("data ready not cleared by buffer read");
  chk_status_clear: assert property (s_lsr_rd |=> lsr_now[4:1] == 4'h0)
    else $error("error flags not cleared by status read");
  // The move to an idle shifter may re-arm the flag one cycle later, so only the next cycle is checked
  chk_thr_load: assert property (s_thr_wr |=> !lsr_now[5] && !lsr_now[6] && !pend_tx_holding_empty)
    else $error("holding write did not clear empty flags");
  chk_tx_fully_empty_rule: assert property (state_ff.tx_st != TX_IDLE |-> !lsr_now[6])
    else $error("transmitter empty while shifting");
  chk_status_b7: assert property (acc_rd && req.idx == `ULFS_IDX_LSR |-> !o_avs_readdata[7])
    else $error("status bit 7 read as one");
  chk_divisor_access_select_read: assert property (req.rd && state_ff.waitreq && req.idx == `ULFS_IDX_DATA &&
    divisor_access_select |=> o_avs_readdata[7:0] == $past(state_ff.dll))
    else $error("divisor latch not reached with access bit set");

endmodule // ulfs_top

// ---- tb/ulfs_peer.sv ----
// Far-side serial peer: sends characters into the receiver and decodes the transmitter.
// Assumes the divisor stays at one, so a bit lasts 16 clock cycles.
`timescale 1ns/1ps
module ulfs_peer (
  // Clock
  input wire logic i_clk,
  // Serial lines
  input wire logic i_tx_line,
  output logic o_rx_line
);
  int cyc = 0;
  int nbits = 5;
  logic parity_on = 1'b0;
  logic [7:0] capd[$];
  logic capp[$];
  logic caps[$];
  int capt[$];

  initial o_rx_line = 1'b1;

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
  end

  // Samples mid bit; a break also starts a capture, so queues are cleared between tests
  always begin
    logic [7:0] d;
    logic p;
    int t;
    @(negedge i_tx_line);
    t = cyc;
    d = 8'h00;
    p = 1'b0;
    repeat (8) @(posedge i_clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (16) @(posedge i_clk);
      d[i] = i_tx_line;
    end
    if (parity_on) begin
      repeat (16) @(posedge i_clk);
      p = i_tx_line;
    end
    repeat (16) @(posedge i_clk);
    capd.push_back(d);
    capp.push_back(p);
    caps.push_back(i_tx_line);
    capt.push_back(t);
  end

  // Stop level and extra low time let a scenario send framing errors and breaks
  task automatic send(input logic [7:0] d, input int n, input logic p_en, input logic p,
                      input logic stp, input int extra);
    @(posedge i_clk);
    o_rx_line <= 1'b0;
    repeat (16) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      o_rx_line <= d[i];
      repeat (16) @(posedge i_clk);
    end
    if (p_en) begin
      o_rx_line <= p;
      repeat (16) @(posedge i_clk);
    end
    o_rx_line <= stp;
    repeat (16 + extra) @(posedge i_clk);
    o_rx_line <= 1'b1;
  endtask
endmodule // ulfs_peer

// ---- tb/uart_line_format_status_irq_test.sv ----
// Self-checking bench for the serial line block: register access, transmit formats,
// receive status, interrupt priority and masking. Assumes divisor reset value of one.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end

module uart_line_format_status_irq_test;
  import ulfs_pkg::*;
  logic i_clk;
  logic i_rst_n;
  logic [4:0] i_avs_address = 5'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic rx_line;
  logic o_serial_tx_out;
  logic [3:0] mdm_n = 4'hF;
  logic o_intr;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] fl[8] = '{8'h00, 8'h07, 8'h04, 8'h1B, 8'h0A, 8'h3B, 8'h2A, 8'h12};
  logic [7:0] fd[8] = '{8'hA7, 8'h3C, 8'h15, 8'h96, 8'h4B, 8'hE1, 8'h7E, 8'h55};
  logic [7:0] ed[3] = '{8'h5A, 8'h5A, 8'h00};
  logic ep[3] = '{1'b1, 1'b0, 1'b0};
  logic es[3] = '{1'b1, 1'b0, 1'b0};
  int ex[3] = '{0, 0, 64};
  logic [7:0] el[3] = '{8'h65, 8'h69, 8'h79};

  ulfs_top u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_serial_rx_in(rx_line), .o_serial_tx_out(o_serial_tx_out),
    .i_cts_n(mdm_n[0]), .i_dsr_n(mdm_n[1]), .i_ri_n(mdm_n[2]), .i_dcd_n(mdm_n[3]),
    .o_intr(o_intr)
  );

  ulfs_peer u_peer (.i_clk(i_clk), .i_tx_line(o_serial_tx_out), .o_rx_line(rx_line));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low; only the watchdog ends a stuck wait
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    i_avs_address <= {idx, 2'b00};
    i_avs_writedata <= {24'h000000, d};
    i_avs_write <= 1'b1;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    i_avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] idx, output logic [7:0] d);
    @(posedge i_clk);
    i_avs_address <= {idx, 2'b00};
    i_avs_read <= 1'b1;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    d = o_avs_readdata[7:0];
    i_avs_read <= 1'b0;
  endtask

  task automatic chk_reg(input string nm, input logic [2:0] idx, input logic [7:0] e);
    logic [7:0] d;
    rd(idx, d);
    `CHK(nm, e, d)
  endtask

  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (o_intr !== e && n < 600) begin
      @(posedge i_clk);
      n++;
    end
    `CHK("irq", e, o_intr)
  endtask

  task automatic flush_peer();
    u_peer.capd.delete();
    u_peer.capp.delete();
    u_peer.caps.delete();
    u_peer.capt.delete();
  endtask

  // Two characters back to back: the gap between starts is the whole first frame
  task automatic tx_case(input logic [7:0] line_format_control, input logic [7:0] d);
    int n;
    int len;
    int gap;
    int w;
    logic [7:0] m;
    logic p;
    n = 5 + line_format_control[1:0];
    m = 8'hFF >> (8 - n);
    p = line_format_control[5] ? ~line_format_control[4] : (^(d & m)) ^ ~line_format_control[4];
    len = 16 * (1 + n + line_format_control[3]) + (!line_format_control[2] ? 16 : (n == 5 ? 24 : 32));
    u_peer.nbits = n;
    u_peer.parity_on = line_format_control[3];
    flush_peer();
    wr(3, line_format_control);
    wr(0, d);
    wr(0, ~d);
    chk_reg("lsr_busy", 5, 8'h00);
    w = 0;
    while (u_peer.capd.size() < 2 && w < 3000) begin
      @(posedge i_clk);
      w++;
    end
    `CHK("tx_d1", d & m, u_peer.capd[0])
    `CHK("tx_d2", ~d & m, u_peer.capd[1])
    if (line_format_control[3]) `CHK("tx_par", p, u_peer.capp[0])
    `CHK("tx_stop", 1'b1, u_peer.caps[0])
    gap = u_peer.capt[1] - u_peer.capt[0];
    `CHK("tx_len", 1'b1, gap >= len && gap <= len + 8)
    repeat (40) @(posedge i_clk);
    chk_reg("lsr_idle", 5, 8'h60);
  endtask

  initial begin
    i_rst_n = 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    chk_reg("lsr_rst", 5, 8'h60);
    chk_reg("iir_rst", 2, 8'h01);
    chk_reg("lcr_rst", 3, 8'h00);
    wr(5, 8'h1F);
    chk_reg("lsr_ro", 5, 8'h60);
    chk_reg("unmapped", 7, 8'h00);
    wr(1, 8'h05);
    wr(3, 8'h80);
    wr(1, 8'h00);
    chk_reg("dlm", 1, 8'h00);
    chk_reg("dll", 0, 8'h01);
    wr(3, 8'h03);
    chk_reg("ier", 1, 8'h05);
    wr(1, 8'h00);
    foreach (fl[i]) tx_case(fl[i], fd[i]);
    // Receive with two stop bits configured; peer sends only one
    wr(3, 8'h1F);
    wr(1, 8'h05);
    u_peer.send(8'h5A, 8, 1'b1, 1'b0, 1'b1, 0);
    wait_irq(1'b1);
    chk_reg("iir_rda", 2, 8'h04);
    chk_reg("lsr_dr", 5, 8'h61);
    chk_reg("rbr", 0, 8'h5A);
    chk_reg("lsr_rd", 5, 8'h60);
    wait_irq(1'b0);
    u_peer.send(8'h33, 8, 1'b1, 1'b0, 1'b1, 0);
    u_peer.send(8'hC3, 8, 1'b1, 1'b0, 1'b1, 0);
    repeat (32) @(posedge i_clk);
    chk_reg("iir_lsi", 2, 8'h06);
    chk_reg("lsr_oe", 5, 8'h63);
    chk_reg("iir_next", 2, 8'h04);
    chk_reg("lsr_clr", 5, 8'h61);
    chk_reg("rbr_ov", 0, 8'hC3);
    wait_irq(1'b0);
    foreach (ed[i]) begin
      u_peer.send(ed[i], 8, 1'b1, ep[i], es[i], ex[i]);
      wait_irq(1'b1);
      chk_reg("iir_err", 2, 8'h06);
      chk_reg("lsr_err", 5, el[i]);
      chk_reg("lsr_err_clr", 5, 8'h61);
      chk_reg("rbr_err", 0, ed[i]);
      wait_irq(1'b0);
    end
    // Holding-empty source: cleared by an id read, silent while masked
    wr(0, 8'h81);
    wr(1, 8'h02);
    wait_irq(1'b1);
    chk_reg("iir_tx_holding_empty", 2, 8'h02);
    chk_reg("iir_none", 2, 8'h01);
    wait_irq(1'b0);
    wr(1, 8'h00);
    wr(0, 8'h42);
    repeat (400) @(posedge i_clk);
    `CHK("irq_masked", 1'b0, o_intr)
    wr(1, 8'h08);
    @(posedge i_clk);
    mdm_n <= 4'h4;
    wait_irq(1'b1);
    chk_reg("iir_ms", 2, 8'h00);
    chk_reg("msr", 6, 8'hBB);
    chk_reg("iir_ms_clr", 2, 8'h01);
    wait_irq(1'b0);
    wr(1, 8'h00);
    flush_peer();
    wr(3, 8'h43);
    repeat (4) @(posedge i_clk);
    `CHK("brk_on", 1'b0, o_serial_tx_out)
    wr(3, 8'h03);
    repeat (4) @(posedge i_clk);
    `CHK("brk_off", 1'b1, o_serial_tx_out)
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // uart_line_format_status_irq_test
